/* File: design/lbcs_bp_seq.sv */
// Purpose: Backplane phase sequencer with cascade sync drive and realignment.
// Assumes: sync_low is already synchronised to pclk.
// Notes: Phase index counts 0 up to last_phase and wraps.
`timescale 1ns/1ps
module lbcs_bp_seq
  import lbcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [1:0] last_phase,
  input wire logic sync_low,
  output logic [1:0] phase,
  output logic sync_drive
);

  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [1:0] next_phase;
  logic next_sync_drive;

  // Advance the phase timer; jump to the last phase when another driver asserts sync.
  always_comb begin
    next_cnt = cnt;
    next_phase = phase;
    if (phase > last_phase) begin
      next_phase = 2'h0;
      next_cnt = 8'h00;
    end else if (phase != last_phase && cnt >= SYNC_GUARD_CYC && sync_low) begin
      next_phase = last_phase;
      next_cnt = 8'h00;
    end else if (cnt == PHASE_CYC - 8'h01) begin
      next_cnt = 8'h00;
      next_phase = (phase == last_phase) ? 2'h0 : phase + 2'h1;
    end else begin
      next_cnt = cnt + 8'h01;
    end
    next_sync_drive = (next_phase == last_phase);
  end

  // All devices leave reset at phase 0, count 0, so a cascade starts aligned.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      phase <= 2'h0;
      sync_drive <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      phase <= next_phase;
      sync_drive <= next_sync_drive;
    end
  end

endmodule

/* File: design/lbcs_top.sv */
// Purpose: Blink control, display controller and cascade sync for a segment LCD driver.
// Assumes: APB master per the published protocol; pins are asynchronous to pclk.
// Notes: Backplane and segment outputs are digital levels, not bias voltages.
// Overview of operation
// - Rate code 10 is 1 Hz, 11 is 0.5 Hz.
// - Rate code 00 is off, 01 is 2 Hz.
// - Style 0 blanks; style 1 alternates RAM banks.
// - No bank alternation in three or four backplane modes.
// - Drive mode 01 static, 10/11/00 two/three/four backplanes.
// - Controller runs commands, holds status, fills RAM in order.
// - Subaddress pins plus address bit select one of sixteen.
// - Reset starts every driver frame aligned.
// - Sync line is open drain, pulled high otherwise.
// - Assert sync in last phase, watch it elsewhere.
// - Realign to the first driver asserting sync.
`timescale 1ns/1ps
module lbcs_top
  import lbcs_pkg::*;
#(
  parameter int BLINK_TICK_CYC = BLINK_TICK_CYC_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hw_subaddr_bit0,
  input wire logic hw_subaddr_bit1,
  input wire logic hw_subaddr_bit2,
  input wire logic slave_addr_lsb_pin,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic backplane_out_0,
  output logic backplane_out_1,
  output logic backplane_out_2,
  output logic backplane_out_3,
  output logic [SEG_N-1:0] seg_out
);

  // Pin synchronisers: stage one feeds stage two only.
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_raw;

  assign pin_raw = {sync_in, slave_addr_lsb_pin, hw_subaddr_bit2, hw_subaddr_bit1,
                    hw_subaddr_bit0};

  // Two flip-flops per pin before any logic looks at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 5'h1F;
      pin_s2 <= 5'h1F;
    end else if (ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  logic [2:0] pin_subaddr;
  logic pin_sa_lsb;
  logic sync_low;

  assign pin_subaddr = pin_s2[2:0];
  assign pin_sa_lsb = pin_s2[3];
  assign sync_low = ~pin_s2[4];

  // Control state held by the display controller.
  lbcs_mode_s mode;
  lbcs_blink_s blink;
  lbcs_devsel_s devsel;
  logic in_bank;
  logic out_bank;
  logic [4:0] ptr;
  lbcs_mode_s next_mode;
  lbcs_blink_s next_blink;
  lbcs_devsel_s next_devsel;
  logic next_in_bank;
  logic next_out_bank;
  logic [4:0] next_ptr;

  // Display RAM, one 4-bit word per segment.
  logic [3:0] ram [RAM_DEPTH];

  // APB decode.
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic selected;
  logic data_wr;
  logic bank_mode;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign addr_ok = (paddr == REG_MODE) | (paddr == REG_BLINK) | (paddr == REG_BANK) |
                   (paddr == REG_POINTER) | (paddr == REG_DEVSEL) | (paddr == REG_DATA) |
                   (paddr == REG_STATUS);
  // The device takes data writes only when both the address bit and the subaddress match its pins.
  assign selected = (devsel.sa_lsb == pin_sa_lsb) && (devsel.subaddr == pin_subaddr);
  assign data_wr = wr_en & (paddr == REG_DATA) & selected;
  // Bank switching only means something with one or two backplanes.
  assign bank_mode = (mode.drive_mode == LBCS_STATIC) || (mode.drive_mode == LBCS_MUX2);

  // Command execution: settings writes and data pointer handling.
  always_comb begin
    next_mode = mode;
    next_blink = blink;
    next_devsel = devsel;
    next_in_bank = in_bank;
    next_out_bank = out_bank;
    next_ptr = ptr;
    if (wr_en) begin
      case (paddr)
        REG_MODE: begin
          next_mode = lbcs_mode_s'(pwdata[4:0]);
        end
        REG_BLINK: begin
          next_blink = lbcs_blink_s'(pwdata[2:0]);
        end
        REG_BANK: begin
          next_out_bank = pwdata[0];
          next_in_bank = pwdata[1];
        end
        REG_POINTER: begin
          if (pwdata[4:0] <= PTR_LAST) begin
            next_ptr = pwdata[4:0];
          end
        end
        REG_DEVSEL: begin
          next_devsel = lbcs_devsel_s'(pwdata[3:0]);
        end
        default: begin
        end
      endcase
    end
    // Each accepted data word advances the pointer; at the end it wraps to the next device.
    if (data_wr) begin
      if (ptr == PTR_LAST) begin
        next_ptr = 5'h00;
        next_devsel.subaddr = devsel.subaddr + 3'h1;
      end else begin
        next_ptr = ptr + 5'h01;
      end
    end
  end

  // Registers of the display controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RST;
      blink <= BLINK_RST;
      devsel <= DEVSEL_RST;
      in_bank <= 1'b0;
      out_bank <= 1'b0;
      ptr <= 5'h00;
    end else if (ce) begin
      mode <= next_mode;
      blink <= next_blink;
      devsel <= next_devsel;
      in_bank <= next_in_bank;
      out_bank <= next_out_bank;
      ptr <= next_ptr;
    end
  end

  // RAM fill: the bits written depend on the drive mode and the input bank.
  logic [3:0] wr_mask;
  logic [3:0] wr_word;

  always_comb begin
    case (mode.drive_mode)
      LBCS_STATIC: begin
        wr_mask = in_bank ? 4'h4 : 4'h1;
        wr_word = {1'b0, pwdata[0], 1'b0, pwdata[0]};
      end
      LBCS_MUX2: begin
        wr_mask = in_bank ? 4'hC : 4'h3;
        wr_word = {pwdata[1:0], pwdata[1:0]};
      end
      LBCS_MUX3: begin
        wr_mask = 4'h7;
        wr_word = pwdata[3:0];
      end
      default: begin
        wr_mask = 4'hF;
        wr_word = pwdata[3:0];
      end
    endcase
  end

  // RAM has no reset; software fills it before enabling the display.
  always_ff @(posedge pclk) begin
    if (ce && data_wr) begin
      ram[ptr] <= (ram[ptr] & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  // Blink timebase: 250 ms ticks, a 3-bit tick count gives 2, 1 and 0.5 Hz.
  logic [BLINK_CNT_W-1:0] blink_cnt;
  logic [BLINK_CNT_W-1:0] next_blink_cnt;
  logic [2:0] tick_cnt;
  logic [2:0] next_tick_cnt;
  logic blink_half;

  always_comb begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_tick_cnt = tick_cnt;
    if (blink_cnt == BLINK_CNT_W'(BLINK_TICK_CYC - 1)) begin
      next_blink_cnt = '0;
      next_tick_cnt = tick_cnt + 3'h1;
    end
  end

  // Blink timebase registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= '0;
      tick_cnt <= 3'h0;
    end else if (ce) begin
      blink_cnt <= next_blink_cnt;
      tick_cnt <= next_tick_cnt;
    end
  end

  // Select the second half of the blink period for the chosen rate.
  always_comb begin
    case (blink.rate)
      LBCS_BLINK_2HZ: blink_half = tick_cnt[0];
      LBCS_BLINK_1HZ: blink_half = tick_cnt[1];
      LBCS_BLINK_HALF: blink_half = tick_cnt[2];
      default: blink_half = 1'b0;
    endcase
  end

  // Blink effect: blanking for normal style, bank swap for alternation style.
  logic blank_now;
  logic eff_bank;

  assign blank_now = blink_half & ~blink.alt_style;
  assign eff_bank = out_bank ^ (blink_half & blink.alt_style & bank_mode);

  // Backplane sequencing with cascade sync.
  logic [1:0] last_phase;
  logic [1:0] phase;
  logic sync_drive;

  always_comb begin
    case (mode.drive_mode)
      LBCS_STATIC: last_phase = 2'h0;
      LBCS_MUX2: last_phase = 2'h1;
      LBCS_MUX3: last_phase = 2'h2;
      default: last_phase = 2'h3;
    endcase
  end

  lbcs_bp_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .last_phase(last_phase),
    .sync_low(sync_low),
    .phase(phase),
    .sync_drive(sync_drive)
  );

  // Open drain: only ever pulls low; the pull-up holds the line high otherwise.
  assign sync_out = 1'b0;
  assign sync_oe = sync_drive;

  // Segment and backplane outputs, registered.
  logic [1:0] bit_sel;
  logic [SEG_N-1:0] next_seg;
  logic [3:0] bp;
  logic [3:0] next_bp;

  // Banked modes read bit pair 2,3 when the effective output bank is 1.
  assign bit_sel = (bank_mode && eff_bank) ? phase + 2'h2 : phase;

  genvar gi;
  generate
    for (gi = 0; gi < SEG_N; gi = gi + 1) begin : g_seg
      assign next_seg[gi] = mode.enable & ~blank_now & ram[gi][bit_sel];
    end
  endgenerate

  assign next_bp = mode.enable ? (4'h1 << phase) : 4'h0;

  // Output registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_out <= '0;
      bp <= 4'h0;
    end else if (ce) begin
      seg_out <= next_seg;
      bp <= next_bp;
    end
  end

  assign backplane_out_0 = bp[0];
  assign backplane_out_1 = bp[1];
  assign backplane_out_2 = bp[2];
  assign backplane_out_3 = bp[3];

  // Read data is captured in the setup cycle and held through the access cycle.
  logic [31:0] next_prdata;
  logic next_pslverr;

  always_comb begin
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (rd_setup) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = ~addr_ok;
      if (!pwrite) begin
        case (paddr)
          REG_MODE: next_prdata[4:0] = mode;
          REG_BLINK: next_prdata[2:0] = blink;
          REG_BANK: next_prdata[1:0] = {in_bank, out_bank};
          REG_POINTER: next_prdata[4:0] = ptr;
          REG_DEVSEL: next_prdata[3:0] = devsel;
          REG_DATA: next_prdata[3:0] = ram[ptr];
          REG_STATUS: next_prdata[5:0] = {eff_bank, selected, blank_now, sync_low, phase};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

/* File: shared/lbcs_pkg.sv */
// Purpose: Shared constants and types for the blink and cascade sync block.
// Assumes: APB slave with 32-bit data, pclk at 200 MHz.
// Notes: Register offsets are byte addresses of aligned words.
package lbcs_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  // Half period of the 2 Hz blink; slower rates are multiples of it.
  localparam int BLINK_TICK_MS = 250;
  localparam int BLINK_TICK_CYC_DEF = BLINK_TICK_MS * CYC_PER_MS;
  localparam int BLINK_CNT_W = 26;
  // Length of one backplane phase.
  localparam int PHASE_NS = 1000;
  localparam logic [7:0] PHASE_CYC = 8'(PHASE_NS / CLK_PERIOD_NS);
  // Cycles at the start of a phase in which the sync line is not watched.
  localparam logic [7:0] SYNC_GUARD_CYC = 8'h04;

  // Geometry.
  localparam int RAM_DEPTH = 24;
  localparam int SEG_N = 24;
  localparam logic [4:0] PTR_LAST = 5'h17;
  localparam int ADDR_W = 8;

  // Register offsets.
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] REG_BLINK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_BANK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_POINTER = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_DEVSEL = 8'h10;
  localparam logic [ADDR_W-1:0] REG_DATA = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;

  // Drive mode codes.
  typedef enum logic [1:0] {
    LBCS_MUX4 = 2'b00,
    LBCS_STATIC = 2'b01,
    LBCS_MUX2 = 2'b10,
    LBCS_MUX3 = 2'b11
  } lbcs_drive_e;

  // Blink rate codes.
  typedef enum logic [1:0] {
    LBCS_BLINK_OFF = 2'b00,
    LBCS_BLINK_2HZ = 2'b01,
    LBCS_BLINK_1HZ = 2'b10,
    LBCS_BLINK_HALF = 2'b11
  } lbcs_rate_e;

  // Mode register layout, bits 4..0.
  typedef struct packed {
    logic low_power;
    logic enable;
    logic bias_half;
    lbcs_drive_e drive_mode;
  } lbcs_mode_s;

  // Blink register layout, bits 2..0.
  typedef struct packed {
    logic alt_style;
    lbcs_rate_e rate;
  } lbcs_blink_s;

  // Device select register layout, bits 3..0.
  typedef struct packed {
    logic sa_lsb;
    logic [2:0] subaddr;
  } lbcs_devsel_s;

  localparam lbcs_mode_s MODE_RST = '{low_power: 1'b0, enable: 1'b0, bias_half: 1'b0,
                                     drive_mode: LBCS_MUX4};
  localparam lbcs_blink_s BLINK_RST = '{alt_style: 1'b0, rate: LBCS_BLINK_OFF};
  localparam lbcs_devsel_s DEVSEL_RST = '{sa_lsb: 1'b0, subaddr: 3'h0};

endpackage

/* File: test/lbcs_chk_monitor.sv */
// Purpose: Port checker for the blink and cascade sync block.
// Assumes: One clock domain, bound to the top module.
// Notes: Sees only top ports.
`timescale 1ns/1ps
module lbcs_chk_monitor
  import lbcs_pkg::*;
#(
  parameter int BLINK_TICK_CYC = BLINK_TICK_CYC_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe,
  input wire logic backplane_out_0,
  input wire logic backplane_out_1,
  input wire logic backplane_out_2,
  input wire logic backplane_out_3,
  input wire logic [SEG_N-1:0] seg_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] bp;
  logic mapped;
  // Gather the backplanes and decode the mapped word offsets.
  assign bp = {backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= REG_STATUS);
  // Another driver pulls the wire while this one is not driving.
  sequence s_peer_pull;
    !sync_oe && sync_in ##1 !sync_oe && !sync_in;
  endsequence
  // This driver starts to pull the wire.
  sequence s_own_pull;
    !sync_oe ##1 sync_oe;
  endsequence
  a_ready_tie: assert property (pready)
    else $error("pready low");
  a_err_map: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error flag does not match address map");
  a_open_drain: assert property (sync_out == 1'b0)
    else $error("sync wire driven high");
  a_bp_onehot: assert property ($onehot0(bp))
    else $error("more than one backplane active");
  a_sync_stand: assert property (s_own_pull |-> sync_oe [*8])
    else $error("sync pull too short");
  a_bp_sync: assert property ($rose(backplane_out_3) |-> ##[0:2] sync_oe)
    else $error("last backplane without sync pull");
  a_peer_realign: assert property (s_peer_pull |-> ##[1:12] sync_oe)
    else $error("no realignment to the pulling driver");
  a_reset_clean: assert property ($rose(presetn) |-> !sync_oe && bp == 4'h0)
    else $error("outputs active right after reset");
endmodule
bind lbcs_top lbcs_chk_monitor #(.BLINK_TICK_CYC(BLINK_TICK_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .sync_out(sync_out),
  .sync_oe(sync_oe), .backplane_out_0(backplane_out_0), .backplane_out_1(backplane_out_1),
  .backplane_out_2(backplane_out_2), .backplane_out_3(backplane_out_3), .seg_out(seg_out));

/* File: test/lbcs_peer.sv */
// Purpose: Another cascaded driver on the sync wire.
// Assumes: The bench pulses fire for one cycle.
// Notes: Pulls low for one phase, never drives high.
`timescale 1ns/1ps
module lbcs_peer
  import lbcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  output logic pull_oe
);
  logic [7:0] left;
  logic [7:0] next_left;
  // Load a phase on fire, then count it down.
  always_comb begin
    next_left = (left != 8'h00) ? left - 8'h01 : 8'h00;
    if (fire) begin
      next_left = PHASE_CYC;
    end
  end
  // Register the count; quiet after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 8'h00;
    end else begin
      left <= next_left;
    end
  end
  assign pull_oe = (left != 8'h00);
endmodule

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the blink and cascade sync block.
// Assumes: Short blink tick for speed.
// Notes: The sync wire resolves both pulls against a pull-up.
`timescale 1ns/1ps
module testbench
  import lbcs_pkg::*;
;
  localparam int BT = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [2:0] sub = 3'h0;
  logic sa = 1'b0;
  logic fire = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, sync_out, sync_oe, peer_oe, sync_wire, e;
  logic [3:0] bp, sel, mask;
  logic [SEG_N-1:0] seg_out, pat;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n, k;
  int mo[4] = '{1, 2, 3, 0};
  logic [3:0] bpx[4] = '{4'h1, 4'h3, 4'h7, 4'hF};
  // Clock, and the wire level with its pull-up.
  initial forever #2.5 pclk = ~pclk;
  assign sync_wire = (sync_oe ? sync_out : 1'b1) & ~peer_oe;
  lbcs_top #(.BLINK_TICK_CYC(BT)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_subaddr_bit0(sub[0]), .hw_subaddr_bit1(sub[1]),
    .hw_subaddr_bit2(sub[2]), .slave_addr_lsb_pin(sa), .sync_in(sync_wire),
    .sync_out(sync_out), .sync_oe(sync_oe), .backplane_out_0(bp[0]),
    .backplane_out_1(bp[1]), .backplane_out_2(bp[2]), .backplane_out_3(bp[3]),
    .seg_out(seg_out));
  lbcs_peer peer (.pclk(pclk), .presetn(presetn), .fire(fire), .pull_oe(peer_oe));
  // Cut a hang short.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; read data and error land in q and e.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask
  // Fill all 24 places from pointer 0 with one bit each.
  task automatic fill(input logic [23:0] p);
    apb(1'b1, REG_POINTER, 32'h0);
    apb(1'b1, REG_DEVSEL, 32'(sel));
    for (int i = 0; i < 24; i++) begin
      apb(1'b1, REG_DATA, 32'(p[i]));
    end
  endtask
  // Length of one full blank run of the segments.
  task automatic blank_run(output int len);
    len = 0;
    do tick(1); while (seg_out === '0);
    do tick(1); while (seg_out !== '0);
    do begin
      tick(1);
      len++;
    end while (seg_out === '0);
  endtask
  initial begin
    void'($urandom(32'h8D9F));
    @(posedge pclk);
    sub <= 3'($urandom);
    sa <= 1'($urandom);
    pat = 24'($urandom) & 24'hFFFFFE;
    repeat (7) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset value", q, 32'h0);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'(e), 32'h1);
    sel = {sa, sub};
    apb(1'b1, REG_MODE, 32'h9);
    fill('1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("selected", 32'(q[4]), 32'h0);
    apb(1'b0, REG_DEVSEL, 32'h0);
    chk("subaddr", 32'(q[3:0]), 32'({sa, sub + 3'h1}));
    apb(1'b1, REG_DATA, 32'h0);
    apb(1'b0, REG_DATA, 32'h0);
    chk("ignored data", 32'(q[0]), 32'h1);
    apb(1'b1, REG_BANK, 32'h2);
    fill(pat);
    for (int r = 1; r < 4; r++) begin
      apb(1'b1, REG_BLINK, 32'(r));
      blank_run(n);
      chk("blank run", 32'(n), 32'(BT << (r - 1)));
    end
    apb(1'b1, REG_BLINK, 32'h0);
    tick(2);
    k = 0;
    repeat (64) begin
      tick(1);
      k += (seg_out !== '1);
    end
    chk("blink off", 32'(k), 32'h0);
    apb(1'b1, REG_BLINK, 32'h5);
    do tick(1); while (seg_out === '1);
    chk("bank alternation", 32'(seg_out), 32'(pat));
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, REG_MODE, 32'h8 | 32'(mo[j]));
      tick(4);
      mask = 4'h0;
      k = 0;
      repeat (4 * PHASE_CYC + 20) begin
        tick(1);
        mask = mask | bp;
        k += (mo[j] inside {0, 3} && bp[0] && seg_out !== '1);
      end
      chk("backplanes", 32'(mask), 32'(bpx[j]));
      chk("no alternation", 32'(k), 32'h0);
    end
    apb(1'b1, REG_BLINK, 32'h0);
    do tick(1); while (bp[1] !== 1'b1);
    tick(50);
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (sync_oe !== 1'b1 && n < 20);
    // The backplane register follows the phase one edge later than the sync pull.
    tick(1);
    chk("realign", 32'(bp), 32'h8);
    n = 1;
    do begin
      tick(1);
      n++;
    end while (sync_oe === 1'b1);
    chk("sync length", 32'(n), 32'(PHASE_CYC));
    tick(1);
    chk("wrap", 32'(bp), 32'h1);
    give_verdict();
  end
endmodule
